// >>> rtl/status_bit_ops.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module status_bit_ops
    import status_ops_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // APB slave.
    input wire apb_req_type apb_req,
    output apb_rsp_type apb_rsp,
    // Pins and mode outputs.
    output logic external_flag,
    output logic pipeline_flush,
    output logic busy
);
    typedef enum logic [1:0] {IDLE, EXEC, DONE} exec_state_type;

    exec_state_type state_ff, nxt_state;
    logic [15:0] st0_ff, nxt_st0;
    logic [15:0] st1_ff, nxt_st1;
    logic [15:0] repeat_counter_ff;
    logic [15:0] op_ff;
    logic [2:0] cnt_ff;
    logic illegal_ff;
    logic [31:0] prdata_ff;

    wire logic bus_access = apb_req.psel && apb_req.penable;
    wire logic wr_instr = bus_access && apb_req.pwrite && apb_req.paddr == ADDR_INSTR;
    wire logic wr_repeat = bus_access && apb_req.pwrite && apb_req.paddr == ADDR_REPEAT;
    // Instructions are refused while one is executing; pready holds the master off.
    wire logic stall = wr_instr && state_ff != IDLE;
    wire logic issue = wr_instr && state_ff == IDLE;
    wire logic [15:0] new_op = apb_req.pwdata[15:0];
    wire logic is_clr_mask = new_op[15:8] == OP_CLEAR_BITS_HI;
    wire logic [7:0] mask = new_op[7:0];
    wire logic mask_slow = mask[4] || mask[5];
    wire logic is_flush_op = new_op == OP_SET_BLOCK_MAP || new_op == OP_CLR_BLOCK_MAP ||
        new_op == OP_SET_OBJECT_MODE || new_op == OP_CLR_OBJECT_MODE;
    wire logic is_known = is_flush_op || is_clr_mask || new_op == OP_CLR_ADDR_MODE ||
        new_op == OP_CLR_EXT_FLAG || new_op == OP_CLR_OVF_COUNT;
    // Counter clear is only legal with object mode set.
    wire logic ovc_legal = st1_ff[ST1_OBJECT_MODE];
    wire logic [2:0] op_cycles = is_flush_op ? CYC_FLUSH :
        (is_clr_mask && mask_slow) ? CYC_TWO : CYC_ONE;

    // Status update applied on issue, so the new setting holds for the whole flush.
    always_comb begin
        nxt_st0 = st0_ff;
        nxt_st1 = st1_ff;
        if (issue) begin
            case (new_op)
                OP_SET_BLOCK_MAP: nxt_st1[ST1_BLOCK_MAP] = 1'b1;
                OP_CLR_BLOCK_MAP: nxt_st1[ST1_BLOCK_MAP] = 1'b0;
                OP_SET_OBJECT_MODE: nxt_st1[ST1_OBJECT_MODE] = 1'b1;
                OP_CLR_OBJECT_MODE: nxt_st1[ST1_OBJECT_MODE] = 1'b0;
                OP_CLR_ADDR_MODE: nxt_st1[ST1_ADDR_MODE] = 1'b0;
                OP_CLR_EXT_FLAG: nxt_st1[ST1_EXT_FLAG] = 1'b0;
                OP_CLR_OVF_COUNT: begin
                    if (ovc_legal) begin
                        nxt_st0[ST0_OVC_LSB +: 6] = 6'h00;
                    end
                end
                default: begin
                    if (is_clr_mask) begin
                        // Each mask bit clears only its own flag.
                        nxt_st0[ST0_SIGN_EXTEND] = st0_ff[ST0_SIGN_EXTEND] & ~mask[0];
                        nxt_st0[ST0_OVF_SATURATE] = st0_ff[ST0_OVF_SATURATE] & ~mask[1];
                        nxt_st0[ST0_TEST] = st0_ff[ST0_TEST] & ~mask[2];
                        nxt_st0[ST0_CARRY] = st0_ff[ST0_CARRY] & ~mask[3];
                        nxt_st1[ST1_INT_MASK] = st1_ff[ST1_INT_MASK] & ~mask[4];
                        nxt_st1[ST1_DBG_MASK] = st1_ff[ST1_DBG_MASK] & ~mask[5];
                        nxt_st1[ST1_PAGE_ZERO] = st1_ff[ST1_PAGE_ZERO] & ~mask[6];
                        nxt_st1[ST1_VECTOR_MAP] = st1_ff[ST1_VECTOR_MAP] & ~mask[7];
                    end
                end
            endcase
        end else if (bus_access && apb_req.pwrite && apb_req.paddr == ADDR_STATUS0) begin
            nxt_st0 = apb_req.pwdata[15:0];
        end else if (bus_access && apb_req.pwrite && apb_req.paddr == ADDR_STATUS1) begin
            nxt_st1 = apb_req.pwdata[15:0];
        end
    end

    always_comb begin
        case (state_ff)
            IDLE: nxt_state = issue ? (op_cycles == CYC_ONE ? DONE : EXEC) : IDLE;
            EXEC: nxt_state = (cnt_ff == CYC_TWO) ? DONE : EXEC;
            DONE: nxt_state = IDLE;
            default: nxt_state = IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= IDLE;
            st0_ff <= ST0_RESET;
            st1_ff <= ST1_RESET;
            op_ff <= 16'h0000;
            cnt_ff <= 3'h0;
            illegal_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            st0_ff <= nxt_st0;
            st1_ff <= nxt_st1;
            if (issue) begin
                op_ff <= new_op;
                cnt_ff <= op_cycles;
                illegal_ff <= !is_known || (new_op == OP_CLR_OVF_COUNT && !ovc_legal);
            end else if (state_ff == EXEC) begin
                cnt_ff <= cnt_ff - 3'h1;
            end
        end
    end

    // Repeat counter is zeroed by any of these ops; none of them repeats.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            repeat_counter_ff <= 16'h0000;
        end else if (issue) begin
            repeat_counter_ff <= 16'h0000;
        end else if (wr_repeat) begin
            repeat_counter_ff <= apb_req.pwdata[15:0];
        end
    end

    wire logic [31:0] rd_mux =
        apb_req.paddr == ADDR_INSTR ? {15'h0000, illegal_ff, op_ff} :
        apb_req.paddr == ADDR_STATUS0 ? {16'h0000, st0_ff} :
        apb_req.paddr == ADDR_STATUS1 ? {16'h0000, st1_ff} :
        apb_req.paddr == ADDR_CONTROL ? {29'h0, cnt_ff} :
        apb_req.paddr == ADDR_REPEAT ? {16'h0000, repeat_counter_ff} : 32'h0;
    wire logic mapped = apb_req.paddr == ADDR_INSTR || apb_req.paddr == ADDR_STATUS0 ||
        apb_req.paddr == ADDR_STATUS1 || apb_req.paddr == ADDR_CONTROL ||
        apb_req.paddr == ADDR_REPEAT;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_ff <= 32'h0;
        end else if (apb_req.psel && !apb_req.pwrite) begin
            prdata_ff <= rd_mux;
        end
    end

    // Read data is registered in the setup cycle, so every read ends on its first access edge.
    assign apb_rsp.prdata = prdata_ff;
    assign apb_rsp.pready = !stall;
    assign apb_rsp.pslverr = bus_access && !mapped;
    assign external_flag = st1_ff[ST1_EXT_FLAG];
    assign pipeline_flush = state_ff != IDLE && cnt_ff == CYC_FLUSH;
    assign busy = state_ff != IDLE;

    a_flush_length: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && is_flush_op) |=> busy [*5] ##1 !busy)
        else $error("flush op did not take five cycles");
    a_mask_slow: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && is_clr_mask && mask_slow) |=> busy ##1 busy ##1 !busy)
        else $error("slow mask clear not two cycles");
    a_mask_fast: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && is_clr_mask && !mask_slow) |=> busy ##1 !busy)
        else $error("fast mask clear not one cycle");
    a_mask_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && is_clr_mask && mask[4]) |=> !st1_ff[ST1_INT_MASK])
        else $error("interrupt mask not cleared");
    a_mask_keeps: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && is_clr_mask) |=> st0_ff[3:0] == ($past(st0_ff[3:0]) & ~$past(mask[3:0])) &&
        st1_ff[3:0] == ($past(st1_ff[3:0]) & ~$past(mask[7:4])))
        else $error("unselected flag changed");
    a_ovc_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && new_op == OP_CLR_OVF_COUNT && ovc_legal) |=> st0_ff[15:10] == 6'h00)
        else $error("overflow counter not cleared");
    a_ext_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && new_op == OP_CLR_EXT_FLAG) |=> !external_flag)
        else $error("external flag pin not low");
    a_repeat_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
        issue |=> repeat_counter_ff == 16'h0000)
        else $error("repeat counter not reset");
    a_mode_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && new_op == OP_SET_OBJECT_MODE) |=> st1_ff[ST1_OBJECT_MODE] [*5])
        else $error("object mode not held through flush");
    a_addr_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && new_op == OP_CLR_ADDR_MODE) |=> !st1_ff[ST1_ADDR_MODE] && !pipeline_flush)
        else $error("addressing mode clear wrong");
    a_block_map_set: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && new_op == OP_SET_BLOCK_MAP) |=> st1_ff[ST1_BLOCK_MAP] && pipeline_flush)
        else $error("block map set or flush missing");
    a_block_map_clr: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && new_op == OP_CLR_BLOCK_MAP) |=> !st1_ff[ST1_BLOCK_MAP] && pipeline_flush)
        else $error("block map clear or flush missing");
    a_object_clr: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && new_op == OP_CLR_OBJECT_MODE) |=> !st1_ff[ST1_OBJECT_MODE] && pipeline_flush)
        else $error("object mode clear or flush missing");
    a_ovc_refused: assert property (@(posedge sys_clk) disable iff (!resetn)
        (issue && new_op == OP_CLR_OVF_COUNT && !ovc_legal) |=> st0_ff == $past(st0_ff))
        else $error("refused counter clear changed status zero");
    a_flush_single: assert property (@(posedge sys_clk) disable iff (!resetn)
        pipeline_flush |=> !pipeline_flush)
        else $error("flush pulse longer than one cycle");
    a_mode_once: assert property (@(posedge sys_clk) disable iff (!resetn)
        issue |=> busy && !issue)
        else $error("instruction not executed exactly once");

    c_flush_op: cover property (@(posedge sys_clk) issue && is_flush_op);
    c_mask_all: cover property (@(posedge sys_clk) issue && is_clr_mask && mask == 8'hff);
    c_stall: cover property (@(posedge sys_clk) stall);
    c_mask_slow: cover property (@(posedge sys_clk) issue && is_clr_mask && mask_slow);
    c_ovc_refused: cover property (@(posedge sys_clk) issue && new_op == OP_CLR_OVF_COUNT && !ovc_legal);
endmodule : status_bit_ops
`default_nettype wire

// >>> rtl/status_ops_pkg.sv
package status_ops_pkg;
    // Opcode words.
    localparam logic [15:0] OP_SET_BLOCK_MAP = 16'h561a;
    localparam logic [15:0] OP_SET_OBJECT_MODE = 16'h561f;
    localparam logic [15:0] OP_CLR_ADDR_MODE = 16'h5616;
    localparam logic [15:0] OP_CLR_BLOCK_MAP = 16'h563f;
    localparam logic [15:0] OP_CLR_OBJECT_MODE = 16'h5636;
    localparam logic [15:0] OP_CLR_OVF_COUNT = 16'h565c;
    localparam logic [15:0] OP_CLR_EXT_FLAG = 16'h561b;
    localparam logic [7:0] OP_CLEAR_BITS_HI = 8'h29;
    // Cycle counts.
    localparam logic [2:0] CYC_FLUSH = 3'h5;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    // APB register byte addresses.
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_STATUS0 = 8'h04;
    localparam logic [7:0] ADDR_STATUS1 = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0c;
    localparam logic [7:0] ADDR_REPEAT = 8'h10;
    // Status register zero fields.
    localparam int ST0_SIGN_EXTEND = 0;
    localparam int ST0_OVF_SATURATE = 1;
    localparam int ST0_TEST = 2;
    localparam int ST0_CARRY = 3;
    localparam int ST0_OVC_LSB = 10;
    // Status register one fields.
    localparam int ST1_INT_MASK = 0;
    localparam int ST1_DBG_MASK = 1;
    localparam int ST1_PAGE_ZERO = 2;
    localparam int ST1_VECTOR_MAP = 3;
    localparam int ST1_EXT_FLAG = 6;
    localparam int ST1_ADDR_MODE = 8;
    localparam int ST1_OBJECT_MODE = 9;
    localparam int ST1_BLOCK_MAP = 11;
    // Reset values.
    localparam logic [15:0] ST0_RESET = 16'h0000;
    localparam logic [15:0] ST1_RESET = 16'h0000;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;
endpackage : status_ops_pkg

// >>> sim/status_bit_clear_set_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none
module status_bit_clear_set_ops_tb
    import status_ops_pkg::*;
;
    logic sys_clk;
    logic resetn;
    apb_req_type req;
    apb_rsp_type rsp;
    logic external_flag;
    logic pipeline_flush;
    logic busy;
    logic [15:0] st0;
    logic [15:0] st1;
    logic [31:0] r;
    logic [33:0] rd_q[$];
    logic [7:0] busy_q[$];
    logic [3:0] blen = 4'h0;
    logic [3:0] flen = 4'h0;
    // The block map is cleared only for a short migration run and then set again.
    logic [15:0] ops[9] = '{OP_CLR_OBJECT_MODE, OP_CLR_OVF_COUNT, OP_SET_OBJECT_MODE,
        OP_CLR_OVF_COUNT, OP_CLR_BLOCK_MAP, OP_CLR_ADDR_MODE, OP_SET_BLOCK_MAP,
        OP_CLR_EXT_FLAG, 16'h2930};
    int error_cnt = 0;
    int check_count = 0;
    int seed = 4364;
    int i;
    status_bit_ops uut (.sys_clk(sys_clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
        .external_flag(external_flag), .pipeline_flush(pipeline_flush), .busy(busy));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task finish_test;
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task cmp_read(input logic [33:0] e, input logic [33:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("Error read flag/err/data expected %h seen %h", e, s);
        end
    endtask : cmp_read
    task cmp_busy(input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("Error busy flushes/cycles expected %h seen %h", e, s);
        end
    endtask : cmp_busy
    // The request is held until pready is sampled high, as the bus requires.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (rsp.pready !== 1'b1) begin
            n++;
            if (n > 200) begin
                error_cnt++;
                finish_test();
            end
            @(posedge sys_clk);
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task rd(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back({st1[ST1_EXT_FLAG], e});
        apb(a, 1'b0, 32'h0);
    endtask : rd
    task rds;
        rd(ADDR_STATUS0, {17'h0, st0});
        rd(ADDR_STATUS1, {17'h0, st1});
    endtask : rds
    // Overflow counter and external flag are forced nonzero so their clears show.
    // The block map stays set, as software is expected to keep it.
    task set_st;
        r = $random(seed);
        st0 = (r[15:0] & 16'hfc0f) | 16'h8400;
        st1 = (r[31:16] & 16'h034f) | 16'h0840;
        apb(ADDR_STATUS0, 1'b1, {16'h0, st0});
        apb(ADDR_STATUS1, 1'b1, {16'h0, st1});
    endtask : set_st
    task issue(input logic [15:0] op);
        logic [2:0] c;
        logic ok;
        ok = (op != OP_CLR_OVF_COUNT) || st1[ST1_OBJECT_MODE];
        c = CYC_ONE;
        case (op)
            OP_SET_BLOCK_MAP: st1[ST1_BLOCK_MAP] = 1'b1;
            OP_SET_OBJECT_MODE: st1[ST1_OBJECT_MODE] = 1'b1;
            OP_CLR_BLOCK_MAP: st1[ST1_BLOCK_MAP] = 1'b0;
            OP_CLR_OBJECT_MODE: st1[ST1_OBJECT_MODE] = 1'b0;
            OP_CLR_ADDR_MODE: st1[ST1_ADDR_MODE] = 1'b0;
            OP_CLR_EXT_FLAG: st1[ST1_EXT_FLAG] = 1'b0;
            OP_CLR_OVF_COUNT: if (ok) st0[15:10] = 6'h00;
            default: ;
        endcase
        if (op == OP_SET_BLOCK_MAP || op == OP_SET_OBJECT_MODE || op == OP_CLR_BLOCK_MAP
            || op == OP_CLR_OBJECT_MODE) c = CYC_FLUSH;
        if (op[15:8] == OP_CLEAR_BITS_HI) begin
            st0[3:0] = st0[3:0] & ~op[3:0];
            st1[3:0] = st1[3:0] & ~op[7:4];
            if (op[4] || op[5]) c = CYC_TWO;
        end
        busy_q.push_back({3'h0, c == CYC_FLUSH, 1'b0, c});
        apb(ADDR_INSTR, 1'b1, {16'h0, op});
    endtask : issue
    // Busy runs are measured here so back-to-back issues are timed as the design saw them.
    always @(posedge sys_clk) begin
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
            if (rd_q.size() > 0) begin
                cmp_read(rd_q.pop_front(), {external_flag, rsp.pslverr, rsp.prdata});
            end else begin
                error_cnt++;
                $display("Error read expected none seen %h", rsp.prdata);
            end
        end
        if (busy === 1'b1) begin
            blen <= blen + 4'h1;
            flen <= flen + {3'h0, pipeline_flush === 1'b1};
        end else if (blen != 4'h0) begin
            if (busy_q.size() > 0) begin
                cmp_busy(busy_q.pop_front(), {flen, blen});
            end else begin
                error_cnt++;
                $display("Error busy expected none seen %h", {flen, blen});
            end
            blen <= 4'h0;
            flen <= 4'h0;
        end
    end
    initial begin
        repeat (50000) @(posedge sys_clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        req = '0;
        resetn = 1'b0;
        st0 = ST0_RESET;
        st1 = ST1_RESET;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rds();
        rd(8'h14, {1'b1, 32'h0});
        set_st();
        apb(8'h14, 1'b1, r);
        rds();
        for (i = 0; i < 9; i++) begin
            apb(ADDR_REPEAT, 1'b1, {16'h0, r[15:0] | 16'h0001});
            issue(ops[i]);
            if (i == 1) rd(ADDR_INSTR, {17'h1, OP_CLR_OVF_COUNT});
            rd(ADDR_REPEAT, 33'h0);
            rds();
        end
        for (i = 0; i < 11; i++) begin
            set_st();
            issue({OP_CLEAR_BITS_HI, i < 8 ? 8'h01 << i : (i == 8 ? 8'hff : r[7:0])});
            issue(OP_CLR_EXT_FLAG);
            rds();
        end
        repeat (20) @(posedge sys_clk);
        if (busy_q.size() != 0 || rd_q.size() != 0) error_cnt++;
        finish_test();
    end
endmodule : status_bit_clear_set_ops_tb
`default_nettype wire
